// >>> src/pcr_pkg.sv
package pcr_pkg;
   // Geometry
   localparam int          PC_W          = 15;
   localparam int          LATCH_W       = 7;
   localparam int          SP_W          = 5;
   localparam int          STACK_DEPTH   = 16;
   localparam int          ADR_W         = 16;
   // Register offsets as printed, byte address is four times the index
   localparam logic [15:0] IDX_STATUS_SH = 16'h1FE4;
   localparam logic [15:0] IDX_WREG_SH   = 16'h1FE5;
   localparam logic [15:0] IDX_BSR_SH    = 16'h1FE6;
   localparam logic [15:0] IDX_LATH_SH   = 16'h1FE7;
   localparam logic [15:0] IDX_PTR0L_SH  = 16'h1FE8;
   localparam logic [15:0] IDX_PTR0H_SH  = 16'h1FE9;
   localparam logic [15:0] IDX_PTR1L_SH  = 16'h1FEA;
   localparam logic [15:0] IDX_PTR1H_SH  = 16'h1FEB;
   localparam logic [15:0] IDX_SP        = 16'h1FED;
   localparam logic [15:0] IDX_TOS_LO    = 16'h1FEE;
   localparam logic [15:0] IDX_TOS_HI    = 16'h1FEF;
   localparam logic [15:0] IDX_PC_LOW    = 16'h0002;
   localparam logic [15:0] IDX_PC_LATCH  = 16'h000A;
   // Implemented bit masks
   localparam logic [7:0]  MASK_STATUS   = 8'h07;
   localparam logic [7:0]  MASK_BSR      = 8'h1F;
   localparam logic [7:0]  MASK_LATH     = 8'h7F;
   localparam logic [7:0]  MASK_SP       = 8'h1F;
   // Reset values
   localparam logic [14:0] PC_RST        = 15'h0000;
   localparam logic [6:0]  LATCH_RST     = 7'h00;
   localparam logic [4:0]  SP_RST        = 5'h1F;
   localparam logic [7:0]  SHADOW_RST    = 8'h00;
   localparam logic [14:0] STACK_RST     = 15'h0000;
endpackage

// >>> src/pcr_core.sv
`timescale 1ns/10ps
module pcr_core
(
   input  wire logic        CLOCK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [17:0] WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        PC_INC_I,
   input  wire logic        CALL_I,
   input  wire logic        RET_I,
   output logic      [14:0] PC_O,
   output logic      [4:0]  STACK_PTR_O
);

   // Bus decode
   logic        ack_r;
   logic        req;
   logic        wr_en;
   logic [15:0] idx;
   logic        low_lane;
   assign req      = WB_CYC_I & WB_STB_I & ~ack_r;
   assign low_lane = WB_SEL_I[0];
   assign wr_en    = req & WB_WE_I & low_lane;
   assign idx      = WB_ADR_I[17:2];

   // Register select strobes
   logic wr_pcl;
   logic wr_lath;
   logic wr_sp;
   logic wr_top_of_stack_low;
   logic wr_top_of_stack_high;
   assign wr_pcl  = wr_en & (idx == pcr_pkg::IDX_PC_LOW);
   assign wr_lath = wr_en & (idx == pcr_pkg::IDX_PC_LATCH);
   assign wr_sp   = wr_en & (idx == pcr_pkg::IDX_SP);
   assign wr_top_of_stack_low = wr_en & (idx == pcr_pkg::IDX_TOS_LO);
   assign wr_top_of_stack_high = wr_en & (idx == pcr_pkg::IDX_TOS_HI);

   // Shadow registers, one generate loop over the eight contiguous slots
   logic [7:0] shadow_r [8];
   logic [7:0] shadow_mask [8];
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_shadow
         logic hit;
         assign shadow_mask[g] = (g == 0) ? pcr_pkg::MASK_STATUS :
                                 (g == 2) ? pcr_pkg::MASK_BSR :
                                 (g == 3) ? pcr_pkg::MASK_LATH : 8'hFF;
         assign hit = wr_en & (idx == pcr_pkg::IDX_STATUS_SH + 16'(g));
         always_ff @(posedge CLOCK_I)
         begin
            if (SYS_RST_I)
               shadow_r[g] <= pcr_pkg::SHADOW_RST;
            else if (hit)
               shadow_r[g] <= WB_DAT_I[7:0] & shadow_mask[g];
         end
      end
   endgenerate

   // Program counter next value
   logic [14:0] pc_r;
   logic [14:0] pc_nxt;
   logic [6:0]  lath_r;
   logic [14:0] stack_r [16];
   logic [4:0]  sp_r;
   logic [3:0]  slot;
   assign slot = sp_r[3:0];
   always_comb
   begin
      pc_nxt = pc_r;
      if (wr_pcl)
         pc_nxt = {lath_r, WB_DAT_I[7:0]};
      else if (RET_I)
         pc_nxt = stack_r[slot];
      else if (PC_INC_I)
         pc_nxt = 15'(pc_r + 15'h0001);
   end

   // Counter and latch; latch write alone does not touch the counter
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
      begin
         pc_r   <= pcr_pkg::PC_RST;
         lath_r <= pcr_pkg::LATCH_RST;
      end
      else
      begin
         pc_r <= pc_nxt;
         if (wr_lath)
            lath_r <= WB_DAT_I[6:0];
      end
   end

   // Stack pointer: call increments then stores, return reads then decrements
   logic [4:0] sp_nxt;
   logic [4:0] sp_up;
   assign sp_up = 5'(sp_r + 5'h01);
   always_comb
   begin
      sp_nxt = sp_r;
      if (wr_sp)
         sp_nxt = WB_DAT_I[4:0];
      else if (CALL_I)
         sp_nxt = sp_up;
      else if (RET_I)
         sp_nxt = 5'(sp_r - 5'h01);
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
         sp_r <= pcr_pkg::SP_RST;
      else
         sp_r <= sp_nxt;
   end

   // Stack storage, slot addressed by pointer
   generate
      for (g = 0; g < 16; g++)
      begin : g_stack
         always_ff @(posedge CLOCK_I)
         begin
            if (SYS_RST_I)
               stack_r[g] <= pcr_pkg::STACK_RST;
            else if (CALL_I & ~wr_sp & (sp_up[3:0] == 4'(g)))
               stack_r[g] <= 15'(pc_r + 15'h0001);
            else if (wr_top_of_stack_low & (slot == 4'(g)))
               stack_r[g][7:0] <= WB_DAT_I[7:0];
            else if (wr_top_of_stack_high & (slot == 4'(g)))
               stack_r[g][14:8] <= WB_DAT_I[6:0];
         end
      end
   endgenerate

   // Read mux; upper counter bits have no address
   logic [7:0] rd_byte;
   logic       shadow_hit;
   logic [2:0] shadow_idx;
   assign shadow_idx = idx[2:0] - 3'h4;
   assign shadow_hit = (idx >= pcr_pkg::IDX_STATUS_SH) & (idx <= pcr_pkg::IDX_PTR1H_SH);
   assign rd_byte = shadow_hit                   ? shadow_r[shadow_idx] :
                    (idx == pcr_pkg::IDX_PC_LOW)   ? pc_r[7:0] :
                    (idx == pcr_pkg::IDX_PC_LATCH) ? {1'b0, lath_r} :
                    (idx == pcr_pkg::IDX_SP)       ? {3'h0, sp_r} :
                    (idx == pcr_pkg::IDX_TOS_LO)   ? stack_r[slot][7:0] :
                    (idx == pcr_pkg::IDX_TOS_HI)   ? {1'b0, stack_r[slot][14:8]} :
                    8'h00;

   // Single-cycle ack with registered read data
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
      begin
         ack_r    <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end
      else
      begin
         ack_r    <= req;
         WB_DAT_O <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   assign WB_ACK_O    = ack_r;
   assign PC_O        = pc_r;
   assign STACK_PTR_O = sp_r;


   // Reset leaves the counter at zero
   AST_PC_RESET: assert property (@(posedge CLOCK_I) SYS_RST_I |=> PC_O == 15'h0000)
      else $error("counter not cleared by reset");

   // Low byte write loads all fifteen bits
   AST_PCL_LOAD: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      wr_pcl |=> PC_O == {$past(lath_r), $past(WB_DAT_I[7:0])})
      else $error("low byte write did not load all bits");

   // Latch write alone keeps the counter
   AST_LATH_ONLY: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (wr_lath & ~RET_I & ~PC_INC_I) |=> $stable(PC_O))
      else $error("latch write changed the counter");

   // Upper bits come from the latch
   AST_UPPER_SRC: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      wr_pcl |=> PC_O[14:8] == $past(lath_r))
      else $error("upper bits not taken from latch");

   // Gap in the shadow block reads zero
   AST_UNMAPPED: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (req & ~WB_WE_I & (idx == 16'h1FEC)) |=> WB_ACK_O && WB_DAT_O == 32'h0)
      else $error("unmapped read not zero");

   // Call moves the pointer up
   AST_CALL_SP: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (CALL_I & ~wr_sp) |=> STACK_PTR_O == $past(sp_up))
      else $error("call did not increment pointer");

   // Return moves the pointer down
   AST_RET_SP: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (RET_I & ~CALL_I & ~wr_sp) |=> STACK_PTR_O == 5'($past(sp_r) - 5'h01))
      else $error("return did not decrement pointer");

   // Low byte reads back the counter
   AST_PCL_READ: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (req & ~WB_WE_I & (idx == pcr_pkg::IDX_PC_LOW)) |=> WB_DAT_O == {24'h0, $past(pc_r[7:0])})
      else $error("low byte read mismatch");

   // Acknowledge is a single pulse
   AST_ACK_ONE: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      WB_ACK_O |=> ~WB_ACK_O)
      else $error("ack held two cycles");

   // Reset sets the pointer to its top value
   AST_SP_RESET: assert property (@(posedge CLOCK_I) SYS_RST_I |=> STACK_PTR_O == pcr_pkg::SP_RST)
      else $error("pointer not set by reset");

   // Reset quiets the bus outputs
   AST_ACK_RESET: assert property (@(posedge CLOCK_I) SYS_RST_I |=> !WB_ACK_O && WB_DAT_O == 32'h0)
      else $error("bus outputs not quiet after reset");

   // Every accepted request is answered next cycle
   AST_ACK_REQ: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      req |=> WB_ACK_O)
      else $error("request not acknowledged");

   // No acknowledge without a request
   AST_ACK_CAUSE: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      !req |=> !WB_ACK_O)
      else $error("acknowledge without request");

   // Read data is zero outside an answer
   AST_DAT_IDLE: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      !req |=> WB_DAT_O == 32'h0)
      else $error("read data not zero when idle");

   // Unused data lanes always read zero
   AST_DAT_UPPER: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      WB_DAT_O[31:8] == 24'h00_0000)
      else $error("upper data lanes not zero");

   // Latch takes the written bits
   AST_LATH_LOAD: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      wr_lath |=> lath_r == $past(WB_DAT_I[6:0]))
      else $error("latch not loaded");

   // Latch holds unless written
   AST_LATH_HOLD: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      !wr_lath |=> $stable(lath_r))
      else $error("latch changed without write");

   // Increment steps the counter by one with wrap
   AST_PC_INC: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (PC_INC_I & ~wr_pcl & ~RET_I) |=> PC_O == 15'($past(pc_r) + 15'h0001))
      else $error("counter did not increment");

   // Counter holds when nothing loads it
   AST_PC_HOLD: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (~wr_pcl & ~RET_I & ~PC_INC_I) |=> $stable(PC_O))
      else $error("counter changed while idle");

   // Return loads the counter from the slot in use
   AST_PC_RET: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (RET_I & ~wr_pcl) |=> PC_O == $past(stack_r[slot]))
      else $error("return address not loaded");

   // Low byte write sets the low eight bits
   AST_PCL_LOW: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      wr_pcl |=> PC_O[7:0] == $past(WB_DAT_I[7:0]))
      else $error("low byte not loaded");

   // Call stores the next address in the new slot
   AST_CALL_STORE: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (CALL_I & ~wr_sp) |=> stack_r[$past(sp_up[3:0])] == 15'($past(pc_r) + 15'h0001))
      else $error("call did not store return address");

   // Software write sets the pointer
   AST_SP_WRITE: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      wr_sp |=> STACK_PTR_O == $past(WB_DAT_I[4:0]))
      else $error("pointer write lost");

   // Pointer holds without call, return or write
   AST_SP_HOLD: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (~wr_sp & ~CALL_I & ~RET_I) |=> $stable(STACK_PTR_O))
      else $error("pointer changed while idle");

   // Pointer reads back in five bits
   AST_RD_SP: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (req & ~WB_WE_I & (idx == pcr_pkg::IDX_SP)) |=> WB_DAT_O == {27'h0, $past(sp_r)})
      else $error("pointer read mismatch");

   // Latch reads back in seven bits
   AST_RD_LATH: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (req & ~WB_WE_I & (idx == pcr_pkg::IDX_PC_LATCH)) |=> WB_DAT_O == {25'h0, $past(lath_r)})
      else $error("latch read mismatch");

   // Top of stack low byte reads the slot in use
   AST_RD_TOP_OF_STACK_LOW: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (req & ~WB_WE_I & (idx == pcr_pkg::IDX_TOS_LO)) |=> WB_DAT_O == {24'h0, $past(stack_r[slot][7:0])})
      else $error("stack low byte read mismatch");

   // Top of stack high byte reads seven bits
   AST_RD_TOP_OF_STACK_HIGH: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (req & ~WB_WE_I & (idx == pcr_pkg::IDX_TOS_HI)) |=> WB_DAT_O == {25'h0, $past(stack_r[slot][14:8])})
      else $error("stack high byte read mismatch");

   // Write without the low lane is ignored
   AST_SEL_OFF: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (req & WB_WE_I & ~low_lane) |=> $stable(lath_r) && $stable(STACK_PTR_O))
      else $error("write without low lane took effect");

   // Unimplemented status shadow bits stay zero
   AST_SHADOW_MASK: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (shadow_r[0] & ~pcr_pkg::MASK_STATUS) == 8'h00)
      else $error("status shadow reserved bit set");

   // Shadow reads return the stored byte
   AST_RD_SHADOW: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (req & ~WB_WE_I & shadow_hit) |=> WB_DAT_O[7:0] == $past(shadow_r[shadow_idx]))
      else $error("shadow read mismatch");

   // Writes to the counter's upper bits have no address to reach
   AST_NO_UPPER_WR: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      (~wr_pcl & ~RET_I) |=> PC_O[14:8] == $past(pc_r[14:8]) || $past(PC_INC_I))
      else $error("upper bits changed without load");

endmodule

// >>> verif/pcr_core_tb.sv
`timescale 1ns/10ps
module pcr_core_tb;
   logic        clk;
   logic        rst   = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [17:0] adr   = 18'h00000;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] dat_w = 32'h00000000;
   logic [31:0] dat_r;
   logic        ack;
   logic        inc   = 1'b0;
   logic        call  = 1'b0;
   logic        ret   = 1'b0;
   logic [14:0] pc;
   logic [4:0]  sp;
   integer      seed  = 45821;
   int          errors;
   int          compares;
   logic [31:0] q;
   logic [6:0]  h;
   logic [7:0]  l;
   logic [14:0] p;

   pcr_core i_pcr_core (.CLOCK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
      .PC_INC_I(inc), .CALL_I(call), .RET_I(ret), .PC_O(pc), .STACK_PTR_O(sp));

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Counts and verdict, ends the run
   task automatic results();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One comparison, reported at once on mismatch
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Implemented bits of a register index, zero for the unmapped 16'h1FEC, all ones for any other unlisted index
   function automatic logic [7:0] msk(input logic [15:0] idx);
      case (idx)
         pcr_pkg::IDX_STATUS_SH: return pcr_pkg::MASK_STATUS;
         pcr_pkg::IDX_BSR_SH:    return pcr_pkg::MASK_BSR;
         pcr_pkg::IDX_LATH_SH:   return pcr_pkg::MASK_LATH;
         16'h1FEC:               return 8'h00;
         default:                return 8'hFF;
      endcase
   endfunction

   // Classic single Wishbone cycle, entered just after a rising edge
   task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [31:0] r);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'hF;
      dat_w <= {24'h000000, d};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         errors++;
         results();
      end
      else
      begin
         r = dat_r;
         cyc <= 1'b0;
         stb <= 1'b0;
         @(posedge clk);
      end
   endtask

   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      chk({17'h0, pc}, 32'h0);
      chk({27'h0, sp}, {27'h0, pcr_pkg::SP_RST});
      @(posedge clk);
      wb(1'b0, pcr_pkg::IDX_SP, 8'h00, q);
      chk(q, 32'h1F);
      for (int i = 16'h1FE4; i <= 16'h1FEC; i++)
      begin
         l = 8'($random(seed));
         wb(1'b1, 16'(i), l, q);
         wb(1'b0, 16'(i), 8'h00, q);
         chk(q, {24'h0, l & msk(16'(i))});
      end
      for (int k = 0; k < 6; k++)
      begin
         h = 7'($random(seed));
         l = 8'($random(seed));
         if (k == 5)
         begin
            h = 7'h7F;
            l = 8'hFE;
         end
         p = pc;
         wb(1'b1, pcr_pkg::IDX_PC_LATCH, {1'b0, h}, q);
         chk({17'h0, pc}, {17'h0, p});
         wb(1'b0, pcr_pkg::IDX_PC_LATCH, 8'h00, q);
         chk(q, {25'h0, h});
         wb(1'b1, pcr_pkg::IDX_PC_LOW, l, q);
         chk({17'h0, pc}, {17'h0, h, l});
         wb(1'b0, pcr_pkg::IDX_PC_LOW, 8'h00, q);
         chk(q, {24'h0, l});
      end
      // Counting across the top of the 15-bit range
      p = pc + 15'd3;
      inc <= 1'b1;
      repeat (3) @(posedge clk);
      inc <= 1'b0;
      @(posedge clk);
      chk({17'h0, pc}, {17'h0, p});
      // Push then pop of the return address
      p = pc + 15'd1;
      call <= 1'b1;
      @(posedge clk);
      call <= 1'b0;
      @(posedge clk);
      chk({27'h0, sp}, 32'h0);
      wb(1'b0, pcr_pkg::IDX_TOS_LO, 8'h00, q);
      chk(q, {24'h0, p[7:0]});
      wb(1'b0, pcr_pkg::IDX_TOS_HI, 8'h00, q);
      chk(q, {25'h0, p[14:8]});
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      @(posedge clk);
      chk({17'h0, pc}, {17'h0, p});
      chk({27'h0, sp}, 32'h1F);
      // Reset in mid-run
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk({17'h0, pc}, 32'h0);
      rst <= 1'b0;
      @(posedge clk);
      chk({17'h0, pc}, 32'h0);
      chk({27'h0, sp}, {27'h0, pcr_pkg::SP_RST});
      wb(1'b0, pcr_pkg::IDX_PC_LATCH, 8'h00, q);
      chk(q, 32'h0);
      results();
   end
endmodule
